/* sim/rcd_ctrl_model.sv */
/* memory controller model: reset pin, clock enables, chip selects, stop.
   assumes requests from the bench; drives on falling mclk. */
`timescale 1ns/1ps
module rcd_ctrl_model (
   // clock, reset, requests
   input wire mclk,
   input wire rst,
   input wire want_up,
   input wire want_stop,
   input wire [1:0] cke_req,
   input wire [1:0] cs_req,
   // controller pins
   output reg reset_pin_n,
   output reg ck_stopped,
   output reg cke_in_zero,
   output reg cke_in_one,
   output reg [1:0] chip_select_inputs
);
   // ****
   // quiet and stop sequencing
   // ****
   reg [3:0] lo_cnt_r;
   always @(negedge mclk) begin
      if (rst) begin
         reset_pin_n <= 1'b0;
         ck_stopped <= 1'b0;
         {cke_in_one, cke_in_zero} <= 2'h0;
         chip_select_inputs <= 2'h3;
         lo_cnt_r <= 4'h0;
      end else begin
         // saturating count of cke-low cycles
         lo_cnt_r <= (cke_in_zero || cke_in_one) ? 4'h0 :
            lo_cnt_r + {3'h0, lo_cnt_r != 4'hf};
         reset_pin_n <= want_up &&
            (reset_pin_n || lo_cnt_r >= 4'h8);
         ck_stopped <= want_stop && reset_pin_n &&
            (ck_stopped || lo_cnt_r >= 4'h5);
         {cke_in_one, cke_in_zero} <= (!want_up || !reset_pin_n ||
            want_stop || ck_stopped) ? 2'h0 : cke_req;
         chip_select_inputs <= reset_pin_n ? cs_req : 2'h3;
      end
   end
endmodule

/* sim/rcd_power_save_tb.sv */
/* self-checking bench for rcd_power_save with a controller model.
   assumes 100 mhz mclk; inputs change on falling edges only. */
`timescale 1ns/1ps
module rcd_power_save_tb;
   reg mclk, rst, want_up, want_stop, cw_wr;
   reg [1:0] cke_req, cs_req;
   reg [21:0] cmd_in, exp_q;
   reg [3:0] cw_addr, cw_data;
   wire reset_pin_n, ck_stopped, cke_in_zero, cke_in_one, cmd_oe;
   wire in_buf_en, cke_buf_en, static_valid, power_save;
   wire [1:0] chip_select_inputs, cke_out_copies, cs_out;
   wire [21:0] cmd_out;
   integer fails = 0, comparisons = 0, cycles = 0, i, n;
   rcd_ctrl_model i_ctrl (.mclk, .rst, .want_up, .want_stop, .cke_req,
      .cs_req, .reset_pin_n, .ck_stopped, .cke_in_zero, .cke_in_one,
      .chip_select_inputs);
   rcd_power_save i_dut (.mclk, .rst, .reset_pin_n, .ck_stopped,
      .cke_in_zero, .cke_in_one, .chip_select_inputs, .cmd_in, .cw_wr,
      .cw_addr, .cw_data, .cke_out_copies, .cs_out, .cmd_out, .cmd_oe,
      .in_buf_en, .cke_buf_en, .static_valid, .power_save);
   // ****
   // helpers
   // ****
   task tick(input integer k);
      repeat (k) @(negedge mclk);
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function [21:0] next_cmd(input [21:0] old, nw, input [1:0] cs);
      next_cmd = (cs == 2'h1 || cs == 2'h2) ? nw : old;
   endfunction
   task wcw(input [3:0] a, input [3:0] d);
      cw_addr <= a;
      cw_data <= d;
      cw_wr <= 1'b1;
      tick(1);
      cw_wr <= 1'b0;
      tick(8);
   endtask
   task nap(input en, input stop, input integer hold);
      cke_req <= 2'h0;
      tick(6);
      chk({in_buf_en, power_save, cmd_oe}, en ? 3'b010 : 3'b101);
      chk(cs_out, en ? 2'h3 : cs_req);
      want_stop <= stop;
      tick(hold);
      chk(cke_buf_en, !(en && stop));
      want_stop <= 1'b0;
      tick(1);
      cke_req <= 2'(1 + $urandom % 3);
      tick(5);
      chk({static_valid, power_save, in_buf_en, cke_buf_en}, 4'hb);
   endtask
   task tally_and_finish;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   // ****
   // main sequence
   // ****
   initial begin
      {rst, want_up, want_stop, cw_wr} = 4'h8;
      {cke_req, cs_req, cmd_in, cw_addr, cw_data, exp_q} = 0;
      void'($urandom(88110));
      tick(16);
      rst <= 1'b0;
      want_up <= 1'b1;
      tick(3);
      chk({reset_pin_n, cs_out}, 3'h3);
      for (n = 0; reset_pin_n !== 1'b1 && n < 20; n = n + 1)
         tick(1);
      tick(2);
      chk(static_valid, 1);
      for (i = 0; i < 24; i = i + 1) begin
         cs_req <= $urandom;
         tick(1);
         cmd_in <= $urandom;
         tick(1);
         exp_q = next_cmd(exp_q, cmd_in, cs_req);
         chk({cs_out, cmd_out}, {cs_req, exp_q});
      end
      wcw(4'h8, 4'h2);
      nap(0, 1, 7);
      wcw(4'h9, 4'h2);
      nap(1, 0, 6);
      for (i = 0; i < 3; i = i + 1)
         nap(1, 1, 6 + $urandom % 7);
      wcw(4'h9, 4'h0);
      nap(0, 0, 6);
      want_up <= 1'b0;
      tick(3);
      chk({static_valid, cs_out, cke_out_copies}, 5'h0c);
      tally_and_finish;
   end
endmodule

/* sim/rcd_ps_props.sv */
/* checker for the clock-enable power-saving sequencer.
   sees only top-level ports; bound into rcd_power_save below. */
`timescale 1ns/1ps
`include "rcd_consts.vh"
module rcd_ps_props (
   input wire mclk,
   input wire rst,
   input wire reset_pin_n,
   input wire ck_stopped,
   input wire cke_in_zero,
   input wire cke_in_one,
   input wire cw_wr,
   input wire [3:0] cw_addr,
   input wire [3:0] cw_data,
   input wire [1:0] cke_out_copies,
   input wire cmd_oe,
   input wire in_buf_en,
   input wire cke_buf_en,
   input wire static_valid,
   input wire power_save
);
   // ****
   // shadow of the enable field
   // ****
   reg field_r;
   wire cke_lo = !cke_in_zero && !cke_in_one;
   wire q_lo = cke_out_copies == 2'h0;
   always @(posedge mclk) begin
      if (rst || !reset_pin_n)
         field_r <= 1'b0;
      else if (cw_wr && cw_addr == `RCD_CW_PS_ADDR)
         field_r <= cw_data[`RCD_CW_PS_EN_BIT];
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_buf_off_late: assert property (
      (field_r && reset_pin_n && cke_lo) [*4] |-> !in_buf_en)
      else $error("input buffers on too long");
   a_buf_off_early: assert property (
      cke_lo && !$past(cke_lo) |-> in_buf_en) else $error("buffers off early");
   a_float_half: assert property (
      $rose(q_lo) && cke_lo && field_r && reset_pin_n |=>
      !cmd_oe && $past(cmd_oe)) else $error("output float mistimed");
   a_cke_rx_hold: assert property (
      $rose(ck_stopped) && cke_lo && power_save |-> cke_buf_en [*3])
      else $error("cke receivers off early");
   a_cke_rx_off: assert property (
      (ck_stopped && cke_lo && power_save) [*5] |-> !cke_buf_en)
      else $error("cke receivers still on");
   a_exit_valid: assert property (
      power_save && reset_pin_n && !cke_lo |-> ##[1:3] static_valid)
      else $error("exit too slow");
   a_exit_bufs: assert property (
      power_save && !cke_lo |=> in_buf_en && cke_buf_en)
      else $error("buffers not back on exit");
   a_plain_cke: assert property (
      !field_r [*3] |-> in_buf_en && !power_save)
      else $error("power save without enable");
   a_cke_follow: assert property (
      cke_out_copies == {$past(cke_in_one), $past(cke_in_zero)})
      else $error("cke copies wrong");
   c_sleep: cover property (power_save ##1 !power_save);
   c_stop: cover property (!cke_buf_en);
   c_float: cover property (!cmd_oe);
endmodule

bind rcd_power_save rcd_ps_props i_props (.mclk, .rst, .reset_pin_n,
   .ck_stopped, .cke_in_zero, .cke_in_one, .cw_wr, .cw_addr, .cw_data,
   .cke_out_copies, .cmd_oe, .in_buf_en, .cke_buf_en, .static_valid,
   .power_save);

/* verilog/rcd_consts.vh */
/*
 * constants for the clock-enable power-saving sequencer: control word
 * location, field positions, reset values and timing counts.
 * assumes the core clock is the register's input clock, one tick per tCK.
 */
`ifndef RCD_CONSTS_VH
`define RCD_CONSTS_VH

// ***********************************************
// control word holding the power-saving enable
// ***********************************************
`define RCD_CW_ADDR_W 4
`define RCD_CW_DATA_W 4
`define RCD_CW_PS_ADDR 4'h9
`define RCD_CW_PS_EN_BIT 1
`define RCD_PS_EN_RST 1'b0

// ***********************************************
// timing, in input clock cycles
// ***********************************************
`define RCD_CYC_PER_TCK 1
`define RCD_PRE_RESET_QUIET_TCK 8
`define RCD_PROGRAM_ACCESS_SPACING_TCK 8
`define RCD_INPUT_BUFFER_OFF_MIN_TCK 1
`define RCD_INPUT_BUFFER_OFF_MAX_TCK 4
`define RCD_CKE_LOW_BEFORE_CLOCK_STOP_TCK 5
`define RCD_CKE_BUFFER_OFF_MIN_TCK 2
`define RCD_EXIT_MIN_TCK 1
`define RCD_EXIT_MAX_TCK 3

// ***********************************************
// derived cycle counts (counter terminal values)
// ***********************************************
// one extra registered stage follows each counter
`define RCD_INDIS_CYC (`RCD_INPUT_BUFFER_OFF_MIN_TCK * `RCD_CYC_PER_TCK)
`define RCD_CKEV_CYC (`RCD_CKE_BUFFER_OFF_MIN_TCK * `RCD_CYC_PER_TCK)
`define RCD_EXIT_CYC (`RCD_EXIT_MIN_TCK * `RCD_CYC_PER_TCK)

`endif

/* verilog/rcd_delay.v */
/*
 * holds a terminal-count flag once a level has stood for a set number
 * of clock cycles; clears at once when the level drops.
 * assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/1ps

module rcd_delay #(
   parameter CNT_W = 4,
   parameter [CNT_W-1:0] COUNT = 4'h2
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // level to time
   input wire run,
   // set after run stood COUNT cycles
   output reg done_r
);

   reg [CNT_W-1:0] cnt_r;

   // ***********************************************
   // counter
   // ***********************************************
   always @(posedge mclk) begin
      if (rst || !run) begin
         cnt_r <= {CNT_W{1'b0}};
         done_r <= 1'b0;
      end else begin
         if (cnt_r != COUNT)
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         // saturates so a long sleep never wraps back to zero
         done_r <= done_r || (cnt_r == COUNT - {{(CNT_W-1){1'b0}}, 1'b1});
      end
   end

endmodule

/* verilog/rcd_power_save.v */
/*
 * clock-enable power-saving sequencer of a registering clock driver:
 * registers clock enables, chip selects and command lines, and walks the
 * input-buffer, output-float, clock-stop and exit sequence.
 * assumes mclk is the input clock while it toggles, that ck_stopped is
 * raised by the clock detector once both clock legs sit low (the core
 * keeps ticking on a local oscillator then), and that all inputs are
 * synchronous to mclk.
 */
// Operation
// - power saving on and both cke low: inputs off 1 to 4 cycles later.
// - command outputs float 1.5 cycles after registered cke goes low.
// - cke receivers turn off no sooner than 2 cycles after clock stop.
// - a cke rising makes static outputs valid again in 1 to 3 cycles.
`timescale 1ns/1ps
`include "rcd_consts.vh"

module rcd_power_save #(
   parameter CS_W = 2,
   parameter DATA_W = 22
) (
   // clock and core reset
   input wire mclk,
   input wire rst,
   // device reset pin and clock detector
   input wire reset_pin_n,
   input wire ck_stopped,
   // clock enables and chip selects
   input wire cke_in_zero,
   input wire cke_in_one,
   input wire [CS_W-1:0] chip_select_inputs,
   // command and address lines
   input wire [DATA_W-1:0] cmd_in,
   // control word programming
   input wire cw_wr,
   input wire [`RCD_CW_ADDR_W-1:0] cw_addr,
   input wire [`RCD_CW_DATA_W-1:0] cw_data,
   // re-driven outputs
   output reg [1:0] cke_out_copies,
   output reg [CS_W-1:0] cs_out,
   output reg [DATA_W-1:0] cmd_out,
   output reg cmd_oe,
   // power state
   output reg in_buf_en,
   output reg cke_buf_en,
   output reg static_valid,
   output reg power_save
);

   // sequencer states
   localparam [1:0] ST_RUN = 2'h0;
   localparam [1:0] ST_SLEEP = 2'h1;
   localparam [1:0] ST_WAKE = 2'h2;
   // counters are four bits wide; the counts are cut to match on purpose
   localparam integer IN_OFF_I = `RCD_INDIS_CYC;
   localparam integer CKE_OFF_I = `RCD_CKEV_CYC;
   localparam integer EXIT_I = `RCD_EXIT_CYC;
   localparam [3:0] IN_OFF_CNT = IN_OFF_I[3:0];
   localparam [3:0] CKE_OFF_CNT = CKE_OFF_I[3:0];
   localparam [3:0] EXIT_CNT = EXIT_I[3:0];

   reg power_save_enable_field_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg cke_out_low_r;
   wire cke_low;
   wire [CS_W-1:0] cs_act;
   wire one_cs;
   wire indis_done;
   wire ckev_done;
   wire exit_done;

   // ***********************************************
   // input decode
   // ***********************************************
   assign cke_low = !cke_in_zero && !cke_in_one;
   assign cs_act = ~chip_select_inputs;
   // a command passes only with exactly one chip select low
   assign one_cs = (cs_act != {CS_W{1'b0}}) &&
      ((cs_act & (cs_act - {{(CS_W-1){1'b0}}, 1'b1})) == {CS_W{1'b0}});

   // ***********************************************
   // power-saving control word
   // ***********************************************
   // each write is taken as it comes; spacing is the controller's job
   always @(posedge mclk) begin
      if (rst || !reset_pin_n)
         power_save_enable_field_r <= `RCD_PS_EN_RST;
      else if (cw_wr && cw_addr == `RCD_CW_PS_ADDR)
         power_save_enable_field_r <= cw_data[`RCD_CW_PS_EN_BIT];
   end

   // ***********************************************
   // delay counters
   // ***********************************************
   rcd_delay #(
      .CNT_W(4),
      .COUNT(IN_OFF_CNT)
   ) u_indis (
      .mclk(mclk),
      .rst(rst),
      .run(power_save_enable_field_r && cke_low && reset_pin_n),
      .done_r(indis_done)
   );

   // clock-stop is only legal after cke stood low long enough
   rcd_delay #(
      .CNT_W(4),
      .COUNT(CKE_OFF_CNT)
   ) u_ckev (
      .mclk(mclk),
      .rst(rst),
      .run(state_r == ST_SLEEP && ck_stopped && cke_low),
      .done_r(ckev_done)
   );

   rcd_delay #(
      .CNT_W(4),
      .COUNT(EXIT_CNT)
   ) u_exit (
      .mclk(mclk),
      .rst(rst),
      .run(state_r == ST_WAKE),
      .done_r(exit_done)
   );

   // ***********************************************
   // sequencer
   // ***********************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (indis_done)
               state_nxt = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (!cke_low)
               state_nxt = ST_WAKE;
         end
         ST_WAKE: begin
            if (exit_done)
               state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
      if (!reset_pin_n)
         state_nxt = ST_RUN;
   end

   always @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_RUN;
         power_save <= 1'b0;
         static_valid <= 1'b0;
      end else begin
         state_r <= state_nxt;
         power_save <= (state_nxt != ST_RUN);
         // outputs are static and valid once back in run
         static_valid <= reset_pin_n &&
            (state_nxt == ST_RUN);
      end
   end

   // ***********************************************
   // buffer enables
   // ***********************************************
   always @(posedge mclk) begin
      if (rst) begin
         in_buf_en <= 1'b1;
         cke_buf_en <= 1'b1;
      end else begin
         // counter plus this stage lands inside the 1..4 cycle window
         in_buf_en <= !(state_nxt == ST_SLEEP);
         // counter plus this stage gives three cycles, never under two
         cke_buf_en <= !ckev_done;
      end
   end

   // ***********************************************
   // re-driven registers
   // ***********************************************
   // device reset pin forces the quiet state the controller also holds
   always @(posedge mclk) begin
      if (rst || !reset_pin_n) begin
         cke_out_copies <= 2'h0;
         cs_out <= {CS_W{1'b1}};
         cmd_out <= {DATA_W{1'b0}};
      end else begin
         // cke copies bypass the input-buffer gate in sleep so the exit is seen
         cke_out_copies <= {cke_in_one, cke_in_zero};
         if (in_buf_en) begin
            cs_out <= chip_select_inputs;
            if (one_cs)
               cmd_out <= cmd_in;
         end else begin
            // inputs off: hold command lines, deselect everything
            cs_out <= {CS_W{1'b1}};
         end
      end
   end

   // ***********************************************
   // output float, half-cycle placement
   // ***********************************************
   always @(posedge mclk) begin
      if (rst)
         cke_out_low_r <= 1'b0;
      else
         cke_out_low_r <= power_save_enable_field_r && reset_pin_n &&
            (cke_out_copies == 2'h0);
   end

   // falling edge after a full cycle of low cke gives exactly 1.5
   always @(negedge mclk) begin
      if (rst)
         cmd_oe <= 1'b1;
      else
         cmd_oe <= !cke_out_low_r;
   end

endmodule
